//--- rtl/sbt_ctrl.sv
// sweep/burst trigger controller: source select, burst cycle count, gate,
// external shift keying and trigger-out on a shared connector
// assumes a single clock; the waveform engine supplies a cycle-end pulse
//
// How it works
// - enabled trigger out gives an edge at each start of a non-external source outside gated and shift keying modes, slope selects polarity
// - immediate or timer source: 50% square wave with period of the interval
// - external source: connector never driven as output
// - bus or manual source: one pulse wider than one microsecond per start
// - immediate source retriggers every interval while active
// - external source: one start per edge of the selected slope
// - manual key starts one run, ignored in remote
// - awaiting key: lamp steady if menu shown or in remote, else blinking
// - bus command starts one run; lamp lit while waiting for it
// - timer source starts a run each programmed period
// - source selection resets to immediate
// - each accepted trigger in sweep mode advances the frequency list
// - triggers only act in sweep or burst operation
// - shift keying: input low selects carrier, high selects hop
// - triggered burst outputs exactly the programmed cycle count
// - gated burst runs while gate true, then finishes cycle and holds phase
// - noise in gated burst stops on the first clock after gate false
// - triggers during a running burst are ignored
// - gate polarity selectable; manual key ignored in gated mode
`timescale 1ns/10ps
`include "sbt_defs.svh"
module sbt_ctrl (
    // clock and reset
    input wire logic clk_in,
    input wire logic resetn_in,
    // configuration
    input wire logic active_in,
    input wire logic sweep_mode_in,
    input wire logic gated_burst_select_in,
    input wire logic external_shift_keying_select_in,
    input wire logic noise_in,
    input wire logic remote_in,
    input wire logic menu_shown_in,
    input wire logic src_load_in,
    input wire logic [1:0] trigger_source_select_in,
    input wire sbt_pkg::sbt_pol_t pol_in,
    input wire logic [31:0] interval_cyc_in,
    input wire logic [31:0] burst_count_in,
    // events
    input wire logic key_press_in,
    input wire logic bus_trig_in,
    input wire logic cycle_end_in,
    input wire logic sweep_done_in,
    // connector
    input wire logic ext_trig_i_in,
    output logic ext_trig_o_out,
    output logic ext_trig_oe_out,
    // engine control
    output logic start_out,
    output logic run_out,
    output logic hold_phase_out,
    output logic list_advance_out,
    output logic hop_select_out,
    output logic key_lamp_out,
    output logic [1:0] source_out
);
    sbt_pkg::sbt_src_t src_r;
    sbt_pkg::sbt_st_t st_r, st_nxt;
    logic sync1_r, sync2_r, sync3_r;
    logic [31:0] tmr_r, ncyc_r, pulse_r, blink_r;
    logic sq_r, pulse_on_r, blink_ph_r, start_r, list_r;
    logic gate_r;

    // synchroniser and edge detect
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            sync1_r <= 1'b0;
            sync2_r <= 1'b0;
            sync3_r <= 1'b0;
        end else begin
            sync1_r <= ext_trig_i_in;
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
        end
    end

    wire rise_w = sync2_r & ~sync3_r;
    wire fall_w = ~sync2_r & sync3_r;
    wire ext_edge_w = pol_in.trig_in_neg ? fall_w : rise_w;
    wire gate_true_w = sync2_r ^ pol_in.gate_inv;
    wire gated_w = gated_burst_select_in & ~sweep_mode_in;
    wire busy_w = (st_r != sbt_pkg::SBT_ST_IDLE);
    wire tick_w = (tmr_r == 32'h0000_0000);
    wire periodic_w = (src_r == sbt_pkg::SBT_SRC_IMM) | (src_r == sbt_pkg::SBT_SRC_TIM);
    wire key_ok_w = key_press_in & ~remote_in & ~gated_w;
    wire trig_w = active_in & ~gated_w & ~busy_w & (
        (periodic_w & tick_w) |
        ((src_r == sbt_pkg::SBT_SRC_EXT) & ext_edge_w) |
        ((src_r == sbt_pkg::SBT_SRC_BUS) & (bus_trig_in | key_ok_w)));
    wire last_cyc_w = cycle_end_in & (ncyc_r == 32'h0000_0001);
    wire half_w = (tmr_r == {1'b0, interval_cyc_in[31:1]});

    // source register
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            src_r <= sbt_pkg::sbt_src_t'(`SBT_SRC_RESET);
        end else if (src_load_in) begin
            src_r <= sbt_pkg::sbt_src_t'(trigger_source_select_in);
        end
    end

    // run state
    always_comb begin
        st_nxt = st_r;
        unique case (st_r)
            sbt_pkg::SBT_ST_IDLE: begin
                if (trig_w) begin
                    st_nxt = sbt_pkg::SBT_ST_RUN;
                end else if (active_in & gated_w & gate_true_w) begin
                    st_nxt = sbt_pkg::SBT_ST_RUN;
                end
            end
            sbt_pkg::SBT_ST_RUN: begin
                if (!active_in) begin
                    st_nxt = sbt_pkg::SBT_ST_IDLE;
                end else if (gated_w) begin
                    if (!gate_true_w) begin
                        st_nxt = noise_in ? sbt_pkg::SBT_ST_IDLE : sbt_pkg::SBT_ST_STOP;
                    end
                end else if (sweep_mode_in ? sweep_done_in : last_cyc_w) begin
                    st_nxt = sbt_pkg::SBT_ST_IDLE;
                end
            end
            sbt_pkg::SBT_ST_STOP: begin
                if (cycle_end_in | !active_in) begin
                    st_nxt = sbt_pkg::SBT_ST_IDLE;
                end
            end
            default: st_nxt = sbt_pkg::SBT_ST_IDLE;
        endcase
    end

    // counters
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            st_r <= sbt_pkg::SBT_ST_IDLE;
            tmr_r <= 32'h0000_0000;
            ncyc_r <= 32'h0000_0000;
            start_r <= 1'b0;
            list_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            start_r <= trig_w;
            list_r <= trig_w & sweep_mode_in;
            if (!active_in | !periodic_w) begin
                tmr_r <= 32'h0000_0000;
            end else if (tick_w) begin
                tmr_r <= interval_cyc_in - 32'h0000_0001;
            end else begin
                tmr_r <= tmr_r - 32'h0000_0001;
            end
            if (trig_w) begin
                ncyc_r <= burst_count_in;
            end else if (cycle_end_in & (ncyc_r != 32'h0000_0000)) begin
                ncyc_r <= ncyc_r - 32'h0000_0001;
            end
        end
    end

    // trigger out square wave and pulse
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            sq_r <= 1'b0;
            pulse_r <= 32'h0000_0000;
            pulse_on_r <= 1'b0;
        end else begin
            if (!periodic_w | !active_in) begin
                sq_r <= 1'b0;
            end else if (trig_w) begin
                sq_r <= 1'b1;
            end else if (half_w) begin
                sq_r <= 1'b0;
            end
            if (trig_w & (src_r == sbt_pkg::SBT_SRC_BUS)) begin
                pulse_r <= 32'(`SBT_PULSE_CYC);
                pulse_on_r <= 1'b1;
            end else if (pulse_r != 32'h0000_0000) begin
                pulse_r <= pulse_r - 32'h0000_0001;
                pulse_on_r <= (pulse_r != 32'h0000_0001);
            end
        end
    end

    // key lamp blinker
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            blink_r <= 32'h0000_0000;
            blink_ph_r <= 1'b0;
        end else if (blink_r == 32'h0000_0000) begin
            blink_r <= `SBT_BLINK_CYC;
            blink_ph_r <= ~blink_ph_r;
        end else begin
            blink_r <= blink_r - 32'h0000_0001;
        end
    end

    // shift keying follows level
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            gate_r <= 1'b0;
        end else begin
            gate_r <= external_shift_keying_select_in & sync2_r;
        end
    end

    wire waiting_w = active_in & ~gated_w & ~busy_w & (src_r == sbt_pkg::SBT_SRC_BUS);
    wire drive_w = pol_in.trig_out_en & active_in & (src_r != sbt_pkg::SBT_SRC_EXT)
        & ~gated_w & ~external_shift_keying_select_in;
    wire level_w = periodic_w ? sq_r : pulse_on_r;

    assign ext_trig_oe_out = drive_w;
    assign ext_trig_o_out = drive_w & (level_w ^ pol_in.trig_out_neg);
    assign start_out = start_r;
    assign run_out = busy_w;
    assign hold_phase_out = ~run_out & ~noise_in & active_in & ~sweep_mode_in;
    assign list_advance_out = list_r;
    assign hop_select_out = gate_r;
    assign key_lamp_out = waiting_w & (menu_shown_in | blink_ph_r | remote_in);
    assign source_out = src_r;

    // checks
    a_ext_no_drive: assert property (@(posedge clk_in) disable iff (!resetn_in)
        (src_r == sbt_pkg::SBT_SRC_EXT) |-> !ext_trig_oe_out)
        else $error("connector driven with external source");
    a_start_follows: assert property (@(posedge clk_in) disable iff (!resetn_in)
        trig_w |=> start_out)
        else $error("start missing after trigger");
    a_busy_ignore: assert property (@(posedge clk_in) disable iff (!resetn_in)
        busy_w |-> !trig_w)
        else $error("trigger accepted while busy");
    a_pulse_width: assert property (@(posedge clk_in) disable iff (!resetn_in)
        $rose(pulse_on_r) |-> pulse_on_r [*8] ##0 (pulse_r > 32'd260))
        else $error("trigger pulse too short");
    a_remote_key: assert property (@(posedge clk_in) disable iff (!resetn_in)
        (remote_in & key_press_in & !bus_trig_in & !ext_edge_w & !tick_w) |-> !trig_w)
        else $error("key accepted in remote");
    a_noise_stop: assert property (@(posedge clk_in) disable iff (!resetn_in)
        ((st_r == sbt_pkg::SBT_ST_RUN) & gated_w & noise_in & active_in & !gate_true_w) |=> !run_out)
        else $error("noise not stopped");
    a_source_reset: assert property (@(posedge clk_in)
        $rose(resetn_in) |-> (src_r == sbt_pkg::SBT_SRC_IMM))
        else $error("source not immediate after reset");
    a_list_step: assert property (@(posedge clk_in) disable iff (!resetn_in)
        (trig_w & sweep_mode_in) |=> list_advance_out)
        else $error("list not advanced");
    a_burst_done: assert property (@(posedge clk_in) disable iff (!resetn_in)
        (run_out & !gated_w & !sweep_mode_in & active_in & last_cyc_w) |=> !run_out)
        else $error("burst overran count");

    // trigger out checks
    a_oe_gated_off: assert property (@(posedge clk_in) disable iff (!resetn_in)
        (gated_w | external_shift_keying_select_in) |-> !ext_trig_oe_out)
        else $error("connector driven in gated or shift keying mode");
    a_out_start_level: assert property (@(posedge clk_in) disable iff (!resetn_in)
        (start_out & ext_trig_oe_out & !$past(src_load_in)) |-> (ext_trig_o_out == !pol_in.trig_out_neg))
        else $error("trigger out edge of wrong slope at start");
    a_square_high: assert property (@(posedge clk_in) disable iff (!resetn_in)
        (periodic_w & active_in & trig_w) |=> sq_r)
        else $error("square wave not high at start");
    a_square_fall: assert property (@(posedge clk_in) disable iff (!resetn_in)
        (periodic_w & active_in & !trig_w & half_w) |=> !sq_r)
        else $error("square wave not low after half period");
    a_pulse_bus_only: assert property (@(posedge clk_in) disable iff (!resetn_in)
        $rose(pulse_on_r) |-> $past(src_r == sbt_pkg::SBT_SRC_BUS))
        else $error("pulse with wrong source");
    a_timer_period: assert property (@(posedge clk_in) disable iff (!resetn_in)
        (periodic_w & active_in & tick_w) |=> (!active_in || !periodic_w
        || $changed(interval_cyc_in) || (tmr_r == interval_cyc_in - 32'h0000_0001)))
        else $error("interval timer not reloaded");
    a_ext_edge_start: assert property (@(posedge clk_in) disable iff (!resetn_in)
        ((src_r == sbt_pkg::SBT_SRC_EXT) & active_in & !gated_w & !busy_w & ext_edge_w) |=> start_out)
        else $error("external edge not started");

    // lamp and keying checks
    a_lamp_steady: assert property (@(posedge clk_in) disable iff (!resetn_in)
        (waiting_w & menu_shown_in) |-> key_lamp_out)
        else $error("lamp not steady with menu shown");
    a_lamp_off: assert property (@(posedge clk_in) disable iff (!resetn_in)
        !waiting_w |-> !key_lamp_out)
        else $error("lamp lit while not waiting");
    a_key_gated: assert property (@(posedge clk_in) disable iff (!resetn_in)
        gated_w |-> !trig_w)
        else $error("trigger accepted in gated mode");
    a_hop_level: assert property (@(posedge clk_in) disable iff (!resetn_in)
        external_shift_keying_select_in |=> (hop_select_out == $past(sync2_r)))
        else $error("hop select does not follow input level");

    // gate checks
    a_gate_finish: assert property (@(posedge clk_in) disable iff (!resetn_in)
        ((st_r == sbt_pkg::SBT_ST_STOP) & cycle_end_in) |=> (st_r == sbt_pkg::SBT_ST_IDLE))
        else $error("gated stop did not end at cycle end");
    a_hold_idle: assert property (@(posedge clk_in) disable iff (!resetn_in)
        ((st_r == sbt_pkg::SBT_ST_IDLE) & active_in & gated_w & !noise_in) |-> hold_phase_out)
        else $error("start phase not held after gate");

    c_ext_start: cover property (@(posedge clk_in) (src_r == sbt_pkg::SBT_SRC_EXT) && trig_w);
    c_gate_hold: cover property (@(posedge clk_in) st_r == sbt_pkg::SBT_ST_STOP);
    c_bus_pulse: cover property (@(posedge clk_in) $fell(pulse_on_r));
    c_square_run: cover property (@(posedge clk_in) sq_r && periodic_w);
    c_list_step: cover property (@(posedge clk_in) list_advance_out);
endmodule : sbt_ctrl

//--- rtl/sbt_defs.svh
// timing and reset constants for the sweep/burst trigger controller
// assumes a 250 MHz system clock
`ifndef SBT_DEFS_SVH
`define SBT_DEFS_SVH
`define SBT_CLK_MHZ 250
`define SBT_PULSE_NS 1100
`define SBT_PULSE_CYC ((`SBT_PULSE_NS * `SBT_CLK_MHZ + 999) / 1000)
`define SBT_BLINK_CYC 32'h0080_0000
`define SBT_SRC_RESET 2'h0
`endif

//--- rtl/sbt_pkg.sv
// types for the sweep/burst trigger controller
// used by sbt_ctrl and its bench
package sbt_pkg;
    typedef enum logic [1:0] {
        SBT_SRC_IMM = 2'b00,
        SBT_SRC_EXT = 2'b01,
        SBT_SRC_BUS = 2'b10,
        SBT_SRC_TIM = 2'b11
    } sbt_src_t;
    typedef enum logic [1:0] {
        SBT_ST_IDLE = 2'b00,
        SBT_ST_RUN = 2'b01,
        SBT_ST_STOP = 2'b10
    } sbt_st_t;
    typedef struct packed {
        logic trig_out_en;
        logic trig_out_neg;
        logic trig_in_neg;
        logic gate_inv;
    } sbt_pol_t;
endpackage : sbt_pkg

//--- tb/sbt_ctrl_tb_top.sv
// bench for the sweep/burst trigger controller
// assumes a 250 MHz clock; the bench plays the waveform engine
`timescale 1ns/10ps
module sbt_ctrl_tb_top;
    logic clk_in, resetn_in, active, sweep, gated, fsk, noise, remote, menu, ld, key, bus;
    logic cyc_end, sdone;
    logic [1:0] src;
    sbt_pkg::sbt_pol_t pol;
    logic [31:0] intv, cnt;
    wire logic conn, lvl, trig_o, trig_oe, start_w, run_w, hold_w, adv_w, hop_w, lamp_w;
    wire logic [1:0] source_w;
    int err_count, checked, starts, hi, ends, oe_hits;

    initial begin
        clk_in = 1'b0;
        forever #2 clk_in = ~clk_in;
    end
    assign conn = trig_oe ? trig_o : lvl;
    sbt_ext_equip i_equip (.clk_in(clk_in), .level_out(lvl));
    sbt_ctrl i_dut (.clk_in(clk_in), .resetn_in(resetn_in), .active_in(active),
        .sweep_mode_in(sweep), .gated_burst_select_in(gated),
        .external_shift_keying_select_in(fsk), .noise_in(noise), .remote_in(remote),
        .menu_shown_in(menu), .src_load_in(ld), .trigger_source_select_in(src),
        .pol_in(pol), .interval_cyc_in(intv), .burst_count_in(cnt), .key_press_in(key),
        .bus_trig_in(bus), .cycle_end_in(cyc_end), .sweep_done_in(sdone),
        .ext_trig_i_in(conn), .ext_trig_o_out(trig_o), .ext_trig_oe_out(trig_oe),
        .start_out(start_w), .run_out(run_w), .hold_phase_out(hold_w),
        .list_advance_out(adv_w), .hop_select_out(hop_w), .key_lamp_out(lamp_w),
        .source_out(source_w));
    // engine model: a cycle end every other clock while running
    always @(posedge clk_in) begin
        cyc_end <= run_w & ~cyc_end;
        if (start_w === 1'b1) starts++;
        if (cyc_end === 1'b1 && run_w === 1'b1) ends++;
        if (source_w == 2'h1 && trig_oe !== 1'b0) oe_hits++;
    end

    task complete_run;
        $display("checks %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : complete_run
    task check(input logic ok, input string msg);
        checked++;
        if (ok !== 1'b1) begin
            err_count++;
            $display("unexpected at %0t: %s", $time, msg);
        end
    endtask : check
    task ticks(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask : ticks
    task wait_start;
        int n;
        n = 0;
        while (start_w !== 1'b1 && n < 3000) begin
            ticks(1);
            n++;
        end
        if (n == 3000) begin
            err_count++;
            $display("unexpected at %0t: no start", $time);
            complete_run();
        end
    endtask : wait_start
    task load_src(input logic [1:0] s);
        @(posedge clk_in);
        src <= s;
        ld <= 1'b1;
        @(posedge clk_in);
        ld <= 1'b0;
        ticks(2);
    endtask : load_src
    task pulse_bus(input logic is_key);
        @(posedge clk_in);
        if (is_key) key <= 1'b1;
        else bus <= 1'b1;
        @(posedge clk_in);
        key <= 1'b0;
        bus <= 1'b0;
        #1;
    endtask : pulse_bus

    initial begin
        {resetn_in, active, sweep, gated, fsk, noise, remote, menu, ld, key, bus} = '0;
        {sdone, src, pol} = '0;
        intv = 32'h0000_0010;
        cnt = 32'h0000_0001;
        pol.trig_out_en = 1'b1;
        repeat (6) @(posedge clk_in);
        resetn_in <= 1'b1;
        ticks(1);
        check(source_w === 2'h0 && start_w === 1'b0, "source after reset");
        active <= 1'b1;
        wait_start();
        hi = 0;
        for (int i = 0; i < 16; i++) begin
            hi += (trig_o === 1'b1);
            ticks(1);
        end
        check(hi == 8, "square duty");
        check(start_w === 1'b1, "restart spacing");
        pol.trig_out_neg <= 1'b1;
        ticks(1);
        wait_start();
        check(trig_o === 1'b0, "negative slope level");
        active <= 1'b0;
        pol.trig_out_neg <= 1'b0;
        $display("test immediate done");
        cnt <= 32'h0000_0003;
        load_src(2'h2);
        active <= 1'b1;
        ticks(30);
        check(lamp_w === 1'b1, "lamp while waiting");
        starts = 0;
        ends = 0;
        pulse_bus(1'b0);
        wait_start();
        check(adv_w === 1'b0, "no list step in burst");
        pulse_bus(1'b0);
        // two high cycles pass during the busy retrigger
        hi = 2;
        while (trig_o === 1'b1 && hi < 400) begin
            ticks(1);
            hi++;
        end
        check(hi == 275, "pulse width");
        check(starts == 1 && ends == 3 && run_w === 1'b0, "burst count");
        $display("test bus done");
        remote <= 1'b1;
        pulse_bus(1'b1);
        ticks(20);
        check(starts == 1, "key in remote");
        remote <= 1'b0;
        menu <= 1'b1;
        ticks(2);
        check(lamp_w === 1'b1, "steady lamp");
        sweep <= 1'b1;
        pulse_bus(1'b1);
        wait_start();
        check(adv_w === 1'b1, "list advance");
        @(posedge clk_in);
        sdone <= 1'b1;
        @(posedge clk_in);
        sdone <= 1'b0;
        sweep <= 1'b0;
        ticks(2);
        check(run_w === 1'b0, "sweep end");
        $display("test key done");
        load_src(2'h1);
        starts = 0;
        i_equip.set_level(1'b1);
        i_equip.set_level(1'b0);
        check(starts == 1 && oe_hits == 0, "one start per edge, no drive");
        fsk <= 1'b1;
        i_equip.set_level(1'b1);
        check(hop_w === 1'b1, "hop on high");
        i_equip.set_level(1'b0);
        check(hop_w === 1'b0, "carrier on low");
        $display("test external done");
        fsk <= 1'b0;
        gated <= 1'b1;
        i_equip.set_level(1'b1);
        check(run_w === 1'b1 && trig_oe === 1'b0, "gate true runs");
        i_equip.set_level(1'b0);
        check(run_w === 1'b0 && hold_w === 1'b1, "gate false holds phase");
        pulse_bus(1'b1);
        ticks(4);
        check(run_w === 1'b0, "key ignored in gated");
        noise <= 1'b1;
        i_equip.set_level(1'b1);
        i_equip.set_level(1'b0);
        check(run_w === 1'b0 && hold_w === 1'b0, "noise stops");
        $display("test gated done");
        complete_run();
    end
endmodule : sbt_ctrl_tb_top

//--- tb/sbt_ext_equip.sv
// external ttl trigger equipment model for the trigger controller bench
// assumes the bench calls set_level from its main sequence
`timescale 1ns/10ps
module sbt_ext_equip #(
    parameter int HOLD_CYC = 1250
) (
    // clock
    input wire logic clk_in,
    // ttl level at the connector
    output logic level_out
);
    initial level_out = 1'b0;
    // new level after a clock edge, then held half of a 100 kHz period
    task set_level(input logic v);
        @(posedge clk_in);
        level_out <= v;
        repeat (HOLD_CYC) @(posedge clk_in);
    endtask : set_level
endmodule : sbt_ext_equip
